// ### hw/opdc_regs.vh
// register offsets, field positions, reset values and codes for the output phase and drive block
// How it works
// - low 13 bits of each phase register are a signed whole-period shift count
// - zero means no shift; negative delays, positive advances, one period per step
// - top three bits of each phase register pick a 45-degree quadrature shift
// - codes 100..111 give 180, +135, +90 and +45 degrees
// - dividers B, C, D each own a phase register affecting only their clocks
// - each phase register spans two byte addresses, read/write, resets to zero
// - each bank's supply code feeds that bank's slew-rate setting
// - slew bit 0 sets outputs 0 and 1: zero medium, one fast
// - slew bits 1, 2, 3 set output pairs 2-3, 4-5, 6-7 alike
`ifndef OPDC_REGS_VH
`define OPDC_REGS_VH
`define OPDC_ADDR_DIVB_LO     8'hd5
`define OPDC_ADDR_DIVB_HI     8'hd6
`define OPDC_ADDR_DIVC_LO     8'hd7
`define OPDC_ADDR_DIVC_HI     8'hd8
`define OPDC_ADDR_DIVD_LO     8'hd9
`define OPDC_ADDR_DIVD_HI     8'hda
`define OPDC_ADDR_SUPPLY      8'hdb
`define OPDC_ADDR_EDGE        8'hdc
`define OPDC_PHASE_RESET      16'h0000
`define OPDC_SUPPLY_RESET     4'hf
`define OPDC_EDGE_RESET       4'h0
`define OPDC_PERIOD_MSB       12
`define OPDC_QUAD_LSB         13
`define OPDC_QUAD_MSB         15
`define OPDC_USED_MASK        8'h0f
`define OPDC_SUPPLY_1V5       2'h0
`define OPDC_SUPPLY_1V8       2'h1
`define OPDC_SUPPLY_2V5       2'h2
`define OPDC_SUPPLY_3V3       2'h3
`define OPDC_DRIVE_WEAK       2'h0
`define OPDC_DRIVE_LOW        2'h1
`define OPDC_DRIVE_MID        2'h2
`define OPDC_DRIVE_HIGH       2'h3
`endif

// ### hw/opdc_drive_calc.v
// drive strength of one configurable output bank from its supply code and edge select
`timescale 1ns/10ps
`default_nettype none
`include "opdc_regs.vh"
module opdc_drive_calc (
    // configuration
    input  wire [1:0] supply_code,
    input  wire [1:0] fast_sel,
    // result per output pair, registered by the caller
    output wire [3:0] drive_code
);
    // lower supply needs more drive for the same edge rate
    function [1:0] opdc_strength;
        input [1:0] sup;
        input       fast;
        begin
            case (sup)
                `OPDC_SUPPLY_1V5: opdc_strength = fast ? `OPDC_DRIVE_HIGH : `OPDC_DRIVE_MID;
                `OPDC_SUPPLY_1V8: opdc_strength = fast ? `OPDC_DRIVE_HIGH : `OPDC_DRIVE_MID;
                `OPDC_SUPPLY_2V5: opdc_strength = fast ? `OPDC_DRIVE_MID : `OPDC_DRIVE_LOW;
                default:          opdc_strength = fast ? `OPDC_DRIVE_LOW : `OPDC_DRIVE_WEAK;
            endcase
        end
    endfunction

    // one strength per output pair of this bank
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_pair
            assign drive_code[2*i+1:2*i] = opdc_strength(supply_code, fast_sel[i]);
        end
    endgenerate
endmodule // opdc_drive_calc
`default_nettype wire

// ### hw/opdc_top.v
// configuration registers for divider phase offsets, bank supply codes and edge rates
`timescale 1ns/10ps
`default_nettype none
`include "opdc_regs.vh"
module opdc_top (
    // clock and reset
    input  wire        clk,
    input  wire        sys_rst,
    // register port, byte wide
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    // divider B phase
    output reg  [12:0] divb_period_offset,
    output reg  [2:0]  divb_quadrature_offset,
    output reg  [3:0]  divb_quad_eighths,
    // divider C phase
    output reg  [12:0] divc_period_offset,
    output reg  [2:0]  divc_quadrature_offset,
    output reg  [3:0]  divc_quad_eighths,
    // divider D phase
    output reg  [12:0] divd_period_offset,
    output reg  [2:0]  divd_quadrature_offset,
    output reg  [3:0]  divd_quad_eighths,
    // bank supply codes
    output reg  [1:0]  first_bank_supply_code,
    output reg  [1:0]  second_bank_supply_code,
    // edge rate per pair, 1 = fast
    output reg  [3:0]  pair_fast,
    // drive strength, two bits per pair, pair 0 lowest
    output reg  [7:0]  pair_drive
);
    // storage
    reg  [15:0] phase_q [0:2];
    reg  [3:0]  supply_q;
    reg  [3:0]  edge_q;
    wire [7:0]  drive_w;
    integer     k;
    // decoded strobes for this cycle
    wire [1:0]  sel_idx;
    wire        phase_wr;
    wire        supply_wr;
    wire        edge_wr;

    // which phase register an address hits; 3 means none
    function [1:0] opdc_phase_idx;
        input [7:0] a;
        begin
            case (a)
                `OPDC_ADDR_DIVB_LO, `OPDC_ADDR_DIVB_HI: opdc_phase_idx = 2'd0;
                `OPDC_ADDR_DIVC_LO, `OPDC_ADDR_DIVC_HI: opdc_phase_idx = 2'd1;
                `OPDC_ADDR_DIVD_LO, `OPDC_ADDR_DIVD_HI: opdc_phase_idx = 2'd2;
                default:                                opdc_phase_idx = 2'd3;
            endcase
        end
    endfunction

    // quadrature code to signed eighths of a period (180 as -4)
    function [3:0] opdc_quad_eighths;
        input [2:0] q;
        begin
            case (q)
                3'h0:    opdc_quad_eighths = 4'h0;
                3'h1:    opdc_quad_eighths = 4'hf;
                3'h2:    opdc_quad_eighths = 4'he;
                3'h3:    opdc_quad_eighths = 4'hd;
                3'h4:    opdc_quad_eighths = 4'hc;
                3'h5:    opdc_quad_eighths = 4'h3;
                3'h6:    opdc_quad_eighths = 4'h2;
                default: opdc_quad_eighths = 4'h1;
            endcase
        end
    endfunction

    // one byte of a phase word; odd address is the low byte
    function [7:0] opdc_phase_byte;
        input [15:0] word;
        input        odd;
        begin
            if (odd) begin
                opdc_phase_byte = word[7:0];
            end else begin
                opdc_phase_byte = word[15:8];
            end
        end
    endfunction

    // address decode shared by the write and read paths
    assign sel_idx   = opdc_phase_idx(reg_addr);
    assign phase_wr  = reg_wr && (sel_idx != 2'd3);
    assign supply_wr = reg_wr && (reg_addr == `OPDC_ADDR_SUPPLY);
    assign edge_wr   = reg_wr && (reg_addr == `OPDC_ADDR_EDGE);

    // phase words; each byte lands on its own, no staging
    always @(posedge clk) begin
        if (sys_rst) begin
            for (k = 0; k < 3; k = k + 1) begin
                phase_q[k] <= `OPDC_PHASE_RESET;
            end
        end else if (phase_wr) begin
            if (reg_addr[0]) begin
                phase_q[sel_idx][7:0] <= reg_wdata;
            end else begin
                phase_q[sel_idx][15:8] <= reg_wdata;
            end
        end
    end

    // bank supply codes; reserved upper bits dropped
    always @(posedge clk) begin
        if (sys_rst) begin
            supply_q <= `OPDC_SUPPLY_RESET;
        end else if (supply_wr) begin
            supply_q <= reg_wdata[3:0];
        end
    end

    // edge rate selects; reserved upper bits dropped
    always @(posedge clk) begin
        if (sys_rst) begin
            edge_q <= `OPDC_EDGE_RESET;
        end else if (edge_wr) begin
            edge_q <= reg_wdata[3:0];
        end
    end

    // read data, reserved and unmapped read zero
    always @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (sel_idx != 2'd3) begin
                reg_rdata <= opdc_phase_byte(phase_q[sel_idx], reg_addr[0]);
            end else if (reg_addr == `OPDC_ADDR_SUPPLY) begin
                reg_rdata <= {4'h0, supply_q};
            end else if (reg_addr == `OPDC_ADDR_EDGE) begin
                reg_rdata <= {4'h0, edge_q};
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    // drive calculation per bank
    opdc_drive_calc u_bank1 (
        .supply_code (supply_q[1:0]),
        .fast_sel    (edge_q[1:0]),
        .drive_code  (drive_w[3:0])
    );
    opdc_drive_calc u_bank2 (
        .supply_code (supply_q[3:2]),
        .fast_sel    (edge_q[3:2]),
        .drive_code  (drive_w[7:4])
    );

    // divider B phase outputs
    always @(posedge clk) begin
        if (sys_rst) begin
            divb_period_offset     <= 13'h0000;
            divb_quadrature_offset <= 3'h0;
            divb_quad_eighths      <= 4'h0;
        end else begin
            divb_period_offset     <= phase_q[0][`OPDC_PERIOD_MSB:0];
            divb_quadrature_offset <= phase_q[0][`OPDC_QUAD_MSB:`OPDC_QUAD_LSB];
            divb_quad_eighths      <= opdc_quad_eighths(phase_q[0][`OPDC_QUAD_MSB:`OPDC_QUAD_LSB]);
        end
    end

    // divider C phase outputs
    always @(posedge clk) begin
        if (sys_rst) begin
            divc_period_offset     <= 13'h0000;
            divc_quadrature_offset <= 3'h0;
            divc_quad_eighths      <= 4'h0;
        end else begin
            divc_period_offset     <= phase_q[1][`OPDC_PERIOD_MSB:0];
            divc_quadrature_offset <= phase_q[1][`OPDC_QUAD_MSB:`OPDC_QUAD_LSB];
            divc_quad_eighths      <= opdc_quad_eighths(phase_q[1][`OPDC_QUAD_MSB:`OPDC_QUAD_LSB]);
        end
    end

    // divider D phase outputs
    always @(posedge clk) begin
        if (sys_rst) begin
            divd_period_offset     <= 13'h0000;
            divd_quadrature_offset <= 3'h0;
            divd_quad_eighths      <= 4'h0;
        end else begin
            divd_period_offset     <= phase_q[2][`OPDC_PERIOD_MSB:0];
            divd_quadrature_offset <= phase_q[2][`OPDC_QUAD_MSB:`OPDC_QUAD_LSB];
            divd_quad_eighths      <= opdc_quad_eighths(phase_q[2][`OPDC_QUAD_MSB:`OPDC_QUAD_LSB]);
        end
    end

    // bank supply codes to the slew calculation
    always @(posedge clk) begin
        if (sys_rst) begin
            first_bank_supply_code  <= `OPDC_SUPPLY_3V3;
            second_bank_supply_code <= `OPDC_SUPPLY_3V3;
        end else begin
            first_bank_supply_code  <= supply_q[1:0];
            second_bank_supply_code <= supply_q[3:2];
        end
    end

    // edge selects and drive strengths per pair
    always @(posedge clk) begin
        if (sys_rst) begin
            pair_fast  <= `OPDC_EDGE_RESET;
            pair_drive <= 8'h00;
        end else begin
            pair_fast  <= edge_q;
            pair_drive <= drive_w;
        end
    end
endmodule // opdc_top
`default_nettype wire

// ### bench/opdc_properties.sv
// port assertions for the phase and drive register block
`timescale 1ns/10ps
`default_nettype none
module opdc_chk (
    // clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // register port
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    // divider outputs
    input wire logic [12:0] divb_period_offset,
    input wire logic [12:0] divc_period_offset,
    input wire logic [12:0] divd_period_offset,
    input wire logic [2:0]  divb_quadrature_offset,
    input wire logic [2:0]  divc_quadrature_offset,
    input wire logic [2:0]  divd_quadrature_offset,
    input wire logic [3:0]  divb_quad_eighths,
    input wire logic [3:0]  divc_quad_eighths,
    input wire logic [3:0]  divd_quad_eighths,
    // bank outputs
    input wire logic [1:0]  first_bank_supply_code,
    input wire logic [1:0]  second_bank_supply_code,
    input wire logic [3:0]  pair_fast,
    input wire logic [7:0]  pair_drive
);
    // expected eighths and drive strength
    function automatic logic [3:0] e8(input logic [2:0] q);
        e8 = (4'h0 - {1'b0, q}) ^ {q[2] & (q[1] | q[0]), 3'h0};
    endfunction
    function automatic logic [1:0] dr(input logic [1:0] s, input logic f);
        dr = (s[1] ? {1'b0, ~s[0]} : 2'h2) + {1'b0, f};
    endfunction
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    period_lo_a: assert property (reg_wr && reg_addr == 8'hd5
        |-> ##2 divb_period_offset[7:0] == $past(reg_wdata, 2)) else $error("period low byte wrong");
    period_hi_a: assert property (reg_wr && reg_addr == 8'hda
        |-> ##2 {3'h0, divd_period_offset[12:8]} == ($past(reg_wdata, 2) & 8'h1f)) else $error("period high wrong");
    quad_field_a: assert property (reg_wr && reg_addr == 8'hd8
        |-> ##2 {divc_quadrature_offset, 5'h0} == ($past(reg_wdata, 2) & 8'he0)) else $error("quadrature wrong");
    quad_map_a: assert property (divb_quad_eighths == e8(divb_quadrature_offset)
        && divc_quad_eighths == e8(divc_quadrature_offset) && divd_quad_eighths == e8(divd_quadrature_offset))
        else $error("quadrature map wrong");
    supply_wr_a: assert property (reg_wr && reg_addr == 8'hdb
        |-> ##2 {4'h0, second_bank_supply_code, first_bank_supply_code} == ($past(reg_wdata, 2) & 8'h0f))
        else $error("supply codes wrong");
    edge_wr_a: assert property (reg_wr && reg_addr == 8'hdc
        |-> ##2 {4'h0, pair_fast} == ($past(reg_wdata, 2) & 8'h0f)) else $error("edge select wrong");
    edge_rd_a: assert property (reg_rd && reg_addr == 8'hdc |=> reg_rdata == {4'h0, pair_fast})
        else $error("edge readback wrong");
    unmapped_rd_a: assert property (reg_rd && (reg_addr < 8'hd5 || reg_addr > 8'hdc)
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    drive_tab_a: assert property (pair_drive[1:0] == dr(first_bank_supply_code, pair_fast[0])
        && pair_drive[3:2] == dr(first_bank_supply_code, pair_fast[1])
        && pair_drive[5:4] == dr(second_bank_supply_code, pair_fast[2])
        && pair_drive[7:6] == dr(second_bank_supply_code, pair_fast[3])) else $error("drive wrong");
    reset_val_a: assert property (disable iff (1'b0) sys_rst |=> divb_period_offset == 13'h0
        && pair_fast == 4'h0 && first_bank_supply_code == 2'h3 && reg_rdata == 8'h00) else $error("reset wrong");
    divc_low_a: assert property (reg_wr && reg_addr == 8'hd7
        |-> ##2 divc_period_offset[7:0] == $past(reg_wdata, 2)) else $error("divider c low byte wrong");
    divd_quad_a: assert property (reg_wr && reg_addr == 8'hda
        |-> ##2 {divd_quadrature_offset, 5'h0} == ($past(reg_wdata, 2) & 8'he0))
        else $error("divider d quadrature wrong");
    cross_write_a: assert property (reg_wr && reg_addr == 8'hd5
        |-> ##2 $stable(divc_period_offset) && $stable(divd_period_offset))
        else $error("write leaked to other divider");
endmodule // opdc_chk
bind opdc_top opdc_chk u_chk (
    .clk                     (clk),
    .sys_rst                 (sys_rst),
    .reg_wr                  (reg_wr),
    .reg_rd                  (reg_rd),
    .reg_addr                (reg_addr),
    .reg_wdata               (reg_wdata),
    .reg_rdata               (reg_rdata),
    .divb_period_offset      (divb_period_offset),
    .divc_period_offset      (divc_period_offset),
    .divd_period_offset      (divd_period_offset),
    .divb_quadrature_offset  (divb_quadrature_offset),
    .divc_quadrature_offset  (divc_quadrature_offset),
    .divd_quadrature_offset  (divd_quadrature_offset),
    .divb_quad_eighths       (divb_quad_eighths),
    .divc_quad_eighths       (divc_quad_eighths),
    .divd_quad_eighths       (divd_quad_eighths),
    .first_bank_supply_code  (first_bank_supply_code),
    .second_bank_supply_code (second_bank_supply_code),
    .pair_fast               (pair_fast),
    .pair_drive              (pair_drive)
);
`default_nettype wire

// ### bench/tb_output_phase_and_drive_config.sv
// self-checking bench for the phase and drive register block
`timescale 1ns/10ps
`default_nettype none
module tb_output_phase_and_drive_config;
    logic       clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d, exp_v;
    logic [7:0] sh [0:7];
    logic [31:0] rnd;
    logic [7:0] exp_q [$];
    integer     seed = 32'he4eb, mismatches = 0, comparisons = 0, n, i;
    // clock at 40 MHz
    always #12.5 clk = ~clk;
    opdc_top u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .divb_period_offset(), .divb_quadrature_offset(),
        .divb_quad_eighths(), .divc_period_offset(), .divc_quadrature_offset(), .divc_quad_eighths(),
        .divd_period_offset(), .divd_quadrature_offset(), .divd_quad_eighths(), .first_bank_supply_code(),
        .second_bank_supply_code(), .pair_fast(), .pair_drive());
    // one byte access; a read queues its expected value
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= w;
        reg_rd <= ~w;
        if (!w) exp_q.push_back(v);
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask
    task close_out();
        if (mismatches == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // compare each read result with the oldest note
    always @(posedge clk) begin
        if (rd_d) begin
            exp_v = exp_q.pop_front();
            comparisons++;
            if (reg_rdata !== exp_v) begin
                mismatches++;
                $display("CHECK FAILED at %0t: got %h expected %h", $time, reg_rdata, exp_v);
            end
        end
        rd_d <= reg_rd;
    end
    // hang guard
    initial begin
        #100000;
        mismatches++;
        close_out();
    end
    // reset values, random passes with every divider B quadrature code, unmapped places, second reset
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 8; i++) acc(1'b0, 8'hd5 + i[7:0], (i == 6) ? 8'h0f : 8'h00);
        for (n = 0; n < 64; n++) begin
            rnd = $random(seed);
            d = rnd[7:0];
            if (n[2:0] == 3'h1) d[7:5] = n[5:3];
            if (n[2:0] == 3'h6) d[3:0] = {n[4:3], ~n[4:3]};
            if (n[2:0] > 3'h5) d = d & 8'h0f;
            sh[n[2:0]] = d;
            acc(1'b1, 8'hd5 + {5'h0, n[2:0]}, d);
            if (n[2:0] == 3'h7) for (i = 0; i < 8; i++) acc(1'b0, 8'hd5 + i[7:0], sh[i]);
        end
        acc(1'b1, 8'hdd, 8'h5a);
        acc(1'b1, 8'hd4, 8'ha5);
        acc(1'b0, 8'hdd, 8'h00);
        acc(1'b0, 8'hd4, 8'h00);
        acc(1'b0, 8'hd5, sh[0]);
        acc(1'b1, 8'hdb, 8'h05);
        acc(1'b1, 8'hd6, 8'hff);
        @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        acc(1'b0, 8'hdb, 8'h0f);
        acc(1'b0, 8'hd6, 8'h00);
        repeat (2) @(posedge clk);
        close_out();
    end
endmodule // tb_output_phase_and_drive_config
`default_nettype wire
